// file: sfi_pkg.sv
// Constants shared by the serial interface fault, interrupt and control block.
// Assumes a 32-bit APB bus, one register per aligned word, byte address = index * 4.
//
// Functional notes
// - Slave: select rising mid-byte sets fault
// - Slave byte: select fall to final idle
// - Select then deselect faults without clocks
// - Deselected slave: output floats, counter cleared
// - Deselected slave ignores clocks, restarts later
// - Select disabled phase 1 slave: always selected, no fault
// - New byte over unread byte flags overrun
// - Overrun keeps old byte, drops new
// - Three request sources, one per flag
// - Complete flag requests only without empty enable
// - Select level against role sets fault
// - Empty flag requests only with empty enable
// - Control register bit layout, eight bits
// - Enable clear resets unit, set runs it
// - Select disable: no select for a master or a phase 1 slave, no fault request
// - Slave phase zero keeps select; select disable still holds its fault request
// - Master bit picks master or slave
// - Polarity bit picks idle clock level
// - Phase bit picks sampling clock edge
// - Rate codes divide clock by 4..128
// - Control register resets to 0x14
// - Overrun set on complete flag, read clears
// - Master fault clears enable and master bits
// - Fault request gated by its enable bit
package sfi_pkg;

  // ***********************************************
  // Register map
  // ***********************************************
  localparam int unsigned ADDR_W    = 10;
  localparam logic [7:0]  CTRL_IDX  = 8'hd4;  // Control register index
  localparam logic [7:0]  STAT_IDX  = 8'hc4;  // Status and control index
  localparam logic [7:0]  DATA_IDX  = 8'hc5;  // Data register index
  localparam logic [ADDR_W-1:0] CTRL_ADDR = {CTRL_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] STAT_ADDR = {STAT_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] DATA_ADDR = {DATA_IDX, 2'b00};

  // ***********************************************
  // Control register fields
  // ***********************************************
  localparam int unsigned CTL_RATE2 = 7;
  localparam int unsigned CTL_EN    = 6;
  localparam int unsigned CTL_SELECT_DISABLE = 5;
  localparam int unsigned CTL_MASTER_SELECT  = 4;
  localparam int unsigned CTL_CPOL  = 3;
  localparam int unsigned CTL_CPHA  = 2;
  localparam int unsigned CTL_RATE1 = 1;
  localparam int unsigned CTL_RATE0 = 0;
  localparam logic [7:0]  CTRL_RST  = 8'h14;

  // ***********************************************
  // Status and control register fields
  // ***********************************************
  localparam int unsigned ST_TC     = 7;
  localparam int unsigned ST_OVR    = 5;
  localparam int unsigned ST_MODE_FAULT_FLAG   = 4;
  localparam int unsigned ST_TE     = 3;
  localparam int unsigned ST_LSB    = 2;
  localparam int unsigned ST_TEIE   = 1;
  localparam int unsigned ST_MODE_FAULT_IRQ_ENABLE = 0;
  localparam logic [7:0]  STAT_RST  = 8'h00;

  // ***********************************************
  // Timing
  // ***********************************************
  localparam logic [6:0]  HALF_MIN  = 7'h02;  // Half period of the divide by 4 rate
  localparam logic [4:0]  LAST_EDGE = 5'h0f;  // Sixteen clock edges per byte

endpackage

// file: sfi_pin_sync.sv
// Three-stage input synchroniser for one pin.
// Assumes the pin is asynchronous to clk; output moves only when stages two and three agree.
`timescale 1ns/100ps
module sfi_pin_sync #(
  parameter logic INIT = 1'b0  // Level shown during reset
) (
  // Clock and reset
  input  logic clk,
  input  logic arst_n,
  // Pin and clean level
  input  logic pin,
  output logic level
);

  // Stage registers and the filtered level
  typedef struct packed {
    logic f1;
    logic f2;
    logic f3;
    logic lvl;
  } sfi_sync_s;

  sfi_sync_s s;       // Current state
  sfi_sync_s next_s;  // Next state

  // ***********************************************
  // Next state
  // ***********************************************
  always_comb begin
    next_s    = s;
    next_s.f1 = pin;
    next_s.f2 = s.f1;
    next_s.f3 = s.f2;
    // Only stages two and three are compared; stage one may be metastable
    if (s.f2 == s.f3) begin
      next_s.lvl = s.f3;
    end
  end

  // State register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= {INIT, INIT, INIT, INIT};
    end else begin
      s <= next_s;
    end
  end

  assign level = s.lvl;

endmodule

// file: sfi_core.sv
// Serial interface core: control register, fault and overrun detection, request line.
// Assumes an APB master on the register side and an external master or slave on the pins.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/100ps
module sfi_core (
  // Clock and reset
  input  logic                       clk,
  input  logic                       arst_n,
  // APB slave
  input  logic                       psel,
  input  logic                       penable,
  input  logic                       pwrite,
  input  logic [sfi_pkg::ADDR_W-1:0] paddr,
  input  logic [31:0]                pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Serial pins
  input  logic                       sck_in,
  output logic                       sck_out,
  output logic                       sck_oe,
  input  logic                       mosi_in,
  output logic                       mosi_out,
  output logic                       mosi_oe,
  input  logic                       miso_in,
  output logic                       miso_out,
  output logic                       miso_oe,
  input  logic                       ss_n_in,
  // Interrupt request
  output logic                       irq
);
  import sfi_pkg::*;

  // ***********************************************
  // State
  // ***********************************************
  typedef struct packed {
    logic [7:0]  ctrl;      // Control register
    logic        tc;        // Transfer complete flag
    logic        overrun_flag;       // Overrun flag
    logic        mode_fault_flag;      // Mode fault flag
    logic        te_ie;     // Transmit empty request enable
    logic        mode_fault_flag_ie;   // Mode fault request enable
    logic        lsb_first; // Bit order select
    logic        tc_armed;  // Status was read with tc set
    logic [7:0]  rx;        // Receive register
    logic [7:0]  sh;        // Shift register
    logic [7:0]  txb;       // Transmit buffer
    logic        txf;       // Transmit buffer holds a byte
    logic        samp;      // Bit sampled on the leading edge
    logic        dout;      // Serial output bit
    logic        act;       // Master transfer running
    logic        sck_o;     // Master clock level
    logic        sel;       // Slave was selected last cycle
    logic        prev_sck;  // Synced clock, last cycle
    logic [4:0]  cnt;       // Clock edges seen in this byte
    logic [6:0]  div;       // Master half period counter
    logic [31:0] prdata;    // Read data for the access phase
    logic        pslverr;   // Error answer for the access phase
  } sfi_state_s;

  sfi_state_s s;       // Current state
  sfi_state_s next_s;  // Next state

  // Synchronised pins
  logic sck_s;   // Serial clock
  logic mosi_s;  // Master out
  logic miso_s;  // Master in
  logic ss_s;    // Select, active low on the wire

  // Pin synchronisers, one per asynchronous input
  sfi_pin_sync #(.INIT(1'b0)) u_sck  (.clk(clk), .arst_n(arst_n), .pin(sck_in),  .level(sck_s));
  sfi_pin_sync #(.INIT(1'b0)) u_mosi (.clk(clk), .arst_n(arst_n), .pin(mosi_in), .level(mosi_s));
  sfi_pin_sync #(.INIT(1'b0)) u_miso (.clk(clk), .arst_n(arst_n), .pin(miso_in), .level(miso_s));
  sfi_pin_sync #(.INIT(1'b1)) u_ss   (.clk(clk), .arst_n(arst_n), .pin(ss_n_in), .level(ss_s));

  // ***********************************************
  // Helpers
  // ***********************************************
  // First bit to send in the chosen order
  function automatic logic first_bit(input logic [7:0] b, input logic lsb);
    first_bit = lsb ? b[0] : b[7];
  endfunction

  // Shift one received bit in, matching the send order
  function automatic logic [7:0] shift_in(input logic [7:0] b, input logic v, input logic lsb);
    shift_in = lsb ? {v, b[7:1]} : {b[6:0], v};
  endfunction

  // ***********************************************
  // Decoded control
  // ***********************************************
  logic       en;         // Interface enable
  logic       select_disable;      // Select disable
  logic       master_select;       // Master role
  logic       cpol;       // Idle clock level
  logic       cpha;       // Sampling edge select
  logic [2:0] rate;       // Rate code
  logic       rate_ok;    // Rate code is usable
  logic [6:0] half;       // Half period in clk cycles
  logic       ss_eff;     // Effective slave select, high = deselected
  logic       slave_sel;  // Slave currently selected
  logic       lead;       // Clock leaves idle
  logic       trail;      // Clock returns to idle
  logic       in_bit;     // Serial input for this role
  logic       done;       // Last edge of a byte
  logic       busy;       // A byte is on the wire
  logic       te;         // Transmit empty flag
  logic       setup;      // APB setup cycle
  logic       access;     // APB access cycle
  logic [7:0] nsh;        // Shift register after a trailing edge

  assign en      = s.ctrl[CTL_EN];
  assign select_disable   = s.ctrl[CTL_SELECT_DISABLE];
  assign master_select    = s.ctrl[CTL_MASTER_SELECT];
  assign cpol    = s.ctrl[CTL_CPOL];
  assign cpha    = s.ctrl[CTL_CPHA];
  assign rate    = {s.ctrl[CTL_RATE2], s.ctrl[CTL_RATE1], s.ctrl[CTL_RATE0]};
  assign rate_ok = (rate != 3'h0) && (rate != 3'h7);
  // Codes 1..6 double the half period each step, from /4 up to /128
  assign half    = HALF_MIN << (rate - 3'h1);

  // Select disable only frees the pin for a slave with phase 1
  assign ss_eff    = (select_disable && cpha) ? 1'b0 : ss_s;
  assign slave_sel = en && !master_select && !ss_eff;

  // Edges come from the divider as master, from the pin as slave
  always_comb begin
    if (master_select) begin
      lead  = s.act && (s.div == 7'h00) && !s.cnt[0];
      trail = s.act && (s.div == 7'h00) && s.cnt[0];
    end else begin
      // Deselected slave sees no edges at all
      lead  = slave_sel && (s.prev_sck == cpol) && (sck_s != cpol);
      trail = slave_sel && (s.prev_sck != cpol) && (sck_s == cpol);
    end
  end

  // As master the reply also passes the pin synchroniser: /4 and /8 take stale bits
  assign in_bit = master_select ? miso_s : mosi_s;
  // Phase 0 holds its bit from the leading edge; phase 1 takes the pin now
  assign nsh    = shift_in(s.sh, cpha ? in_bit : s.samp, s.lsb_first);
  // A byte ends as the clock returns to idle after the eighth bit
  assign done   = trail && (s.cnt == LAST_EDGE);
  assign busy   = s.act || (slave_sel && (s.cnt != 5'h00));
  assign te     = !s.txf;
  assign setup  = psel && !penable;
  assign access = psel && penable;

  // ***********************************************
  // Next state
  // ***********************************************
  always_comb begin
    next_s          = s;
    next_s.prev_sck = sck_s;
    next_s.sel      = slave_sel;

    // Read data is prepared in setup so it leaves a flip-flop
    if (setup) begin
      next_s.pslverr = 1'b0;
      next_s.prdata  = 32'h0000_0000;
      if (paddr == CTRL_ADDR) begin
        next_s.prdata[7:0] = s.ctrl;
      end else if (paddr == STAT_ADDR) begin
        next_s.prdata[ST_TC]     = s.tc;
        next_s.prdata[ST_OVR]    = s.overrun_flag;
        next_s.prdata[ST_MODE_FAULT_FLAG]   = s.mode_fault_flag;
        next_s.prdata[ST_TE]     = te;
        next_s.prdata[ST_LSB]    = s.lsb_first;
        next_s.prdata[ST_TEIE]   = s.te_ie;
        next_s.prdata[ST_MODE_FAULT_IRQ_ENABLE] = s.mode_fault_flag_ie;
      end else if (paddr == DATA_ADDR) begin
        next_s.prdata[7:0] = s.rx;
      end else begin
        // Unmapped word answers with an error and zero data
        next_s.pslverr = 1'b1;
      end
    end

    // Register effects happen only at the end of the access phase
    if (access) begin
      if (paddr == CTRL_ADDR && pwrite) begin
        next_s.ctrl = pwdata[7:0];
      end else if (paddr == STAT_ADDR && pwrite) begin
        next_s.lsb_first = pwdata[ST_LSB];
        next_s.te_ie     = pwdata[ST_TEIE];
        next_s.mode_fault_flag_ie   = pwdata[ST_MODE_FAULT_IRQ_ENABLE];
      end else if (paddr == STAT_ADDR) begin
        // Status read clears the error flags and arms the tc clear
        next_s.overrun_flag      = 1'b0;
        next_s.mode_fault_flag     = 1'b0;
        next_s.tc_armed = s.tc;
      end else if (paddr == DATA_ADDR) begin
        if (s.tc_armed) begin
          next_s.tc       = 1'b0;
          next_s.tc_armed = 1'b0;
        end
        if (pwrite) begin
          if (!master_select && !busy) begin
            // Idle slave: byte goes straight to the shift register
            next_s.sh   = pwdata[7:0];
            next_s.dout = first_bit(pwdata[7:0], s.lsb_first);
          end else begin
            // Otherwise it queues behind the byte on the wire
            next_s.txb = pwdata[7:0];
            next_s.txf = 1'b1;
          end
        end
      end
    end

    // Slave deselect clears the counter and drops the partial byte
    if (!master_select && !slave_sel) begin
      next_s.cnt = 5'h00;
    end

    // Phase 0 slave must present its first bit at the select fall
    if (!master_select && slave_sel && !s.sel && !cpha) begin
      next_s.dout = first_bit(s.sh, s.lsb_first);
    end

    // Master starts a byte when one is queued and the rate is valid
    if (en && master_select && !s.act && s.txf && rate_ok) begin
      next_s.sh    = s.txb;
      next_s.txf   = 1'b0;
      next_s.act   = 1'b1;
      next_s.cnt   = 5'h00;
      next_s.div   = half - 7'h01;
      next_s.sck_o = cpol;
      next_s.dout  = first_bit(s.txb, s.lsb_first);
    end else if (s.act) begin
      // Divider: one clock edge each half period
      if (s.div != 7'h00) begin
        next_s.div = s.div - 7'h01;
      end else begin
        next_s.div   = half - 7'h01;
        next_s.sck_o = !s.sck_o;
      end
    end

    // Leading edge: sample (phase 0) or drive the next bit (phase 1)
    if (lead) begin
      next_s.cnt = s.cnt + 5'h01;
      if (!cpha) begin
        next_s.samp = in_bit;
      end else begin
        next_s.dout = first_bit(s.sh, s.lsb_first);
      end
    end

    // Trailing edge: shift; phase 0 drives its next bit here
    if (trail) begin
      next_s.cnt = s.cnt + 5'h01;
      next_s.sh  = nsh;
      if (!cpha) begin
        next_s.dout = first_bit(nsh, s.lsb_first);
      end
    end

    // End of byte: store it unless the last one is still unread
    if (done) begin
      next_s.cnt = 5'h00;
      next_s.act = 1'b0;
      next_s.tc  = 1'b1;
      if (s.tc) begin
        // New byte is dropped, the unread one stays readable
        next_s.overrun_flag = 1'b1;
      end else begin
        next_s.rx = nsh;
      end
      // Slave sends the queued byte next, else echoes what it got
      if (!master_select && s.txf) begin
        next_s.sh   = s.txb;
        next_s.txf  = 1'b0;
        next_s.dout = first_bit(s.txb, s.lsb_first);
      end
    end

    // Slave deselected after being selected is a fault, clocks or not
    if (en && !master_select && s.sel && ss_s && !(select_disable && cpha)) begin
      next_s.mode_fault_flag = 1'b1;
    end

    // Master sees select pulled low: another master may be driving
    if (en && master_select && !select_disable && !ss_s) begin
      next_s.mode_fault_flag            = 1'b1;
      next_s.ctrl[CTL_EN]    = 1'b0;
      next_s.ctrl[CTL_MASTER_SELECT]  = 1'b0;
    end

    // Disabled unit holds its transfer logic in reset
    if (!en) begin
      next_s.act   = 1'b0;
      next_s.cnt   = 5'h00;
      next_s.div   = 7'h00;
      next_s.sck_o = cpol;
      next_s.txf   = 1'b0;  // A stale queued byte would start on re-enable
    end
  end

  // State register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s      <= '0;
      s.ctrl <= CTRL_RST;
      s.prev_sck <= 1'b0;
      {s.tc, s.overrun_flag, s.mode_fault_flag, s.lsb_first, s.te_ie, s.mode_fault_flag_ie} <= 6'h00;
    end else begin
      s <= next_s;
    end
  end

  // ***********************************************
  // Outputs
  // ***********************************************
  assign prdata   = s.prdata;
  assign pready   = 1'b1;
  assign pslverr  = s.pslverr && access;
  assign sck_out  = s.sck_o;
  assign sck_oe   = en && master_select;
  assign mosi_out = s.dout;
  assign mosi_oe  = en && master_select;
  assign miso_out = s.dout;
  assign miso_oe  = slave_sel;

  // Three sources on one line: tc while te_ie is clear, te while te_ie is set, fault by its own enable while select disable is clear
  assign irq = (s.tc && !s.te_ie)
             || (te && s.te_ie)
             || (s.mode_fault_flag && s.mode_fault_flag_ie && !select_disable);

  // ***********************************************
  // Assertions
  // ***********************************************
  property p_master_fault;
    @(posedge clk) disable iff (!arst_n)
    (en && master_select && !select_disable && !ss_s) |=> (s.mode_fault_flag && !en && !master_select);
  endproperty
  a_master_fault: assert property (p_master_fault) else $error("master fault not taken");

  property p_slave_float;
    @(posedge clk) disable iff (!arst_n)
    (!master_select && ss_eff) |-> (!miso_oe ##1 (s.cnt == 5'h00));
  endproperty
  a_slave_float: assert property (p_slave_float) else $error("deselected slave drives");

  property p_overrun;
    @(posedge clk) disable iff (!arst_n)
    (done && s.tc) |=> (s.overrun_flag && $stable(s.rx));
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun lost old byte");

  property p_tc_req;
    @(posedge clk) disable iff (!arst_n)
    ($rose(s.tc) && !s.te_ie) |-> irq;
  endproperty
  a_tc_req: assert property (p_tc_req) else $error("complete request missing");

  property p_te_req;
    @(posedge clk) disable iff (!arst_n)
    (s.te_ie && !s.txf) |-> irq;
  endproperty
  a_te_req: assert property (p_te_req) else $error("empty request missing");

  property p_disable;
    @(posedge clk) disable iff (!arst_n)
    !en |=> (!s.act && s.cnt == 5'h00);
  endproperty
  a_disable: assert property (p_disable) else $error("disabled unit still active");

  property p_rate_bad;
    @(posedge clk) disable iff (!arst_n)
    (!rate_ok && !s.act) |=> !s.act;
  endproperty
  a_rate_bad: assert property (p_rate_bad) else $error("invalid rate started a byte");

  property p_half_fast;
    @(posedge clk) disable iff (!arst_n)
    (s.act && rate == 3'h1 && $changed(sck_out) && $stable(s.ctrl)) |=> $stable(sck_out);
  endproperty
  a_half_fast: assert property (p_half_fast) else $error("clock half period short");

  property p_slave_fault;
    @(posedge clk) disable iff (!arst_n)
    (en && !master_select && s.sel && ss_s && !(select_disable && cpha)) |=> s.mode_fault_flag;
  endproperty
  a_slave_fault: assert property (p_slave_fault) else $error("slave fault not set");

  property p_select_disable_slave;
    @(posedge clk) disable iff (!arst_n)
    (en && !master_select && select_disable && cpha && !s.mode_fault_flag && !access) |=> !s.mode_fault_flag;
  endproperty
  a_select_disable_slave: assert property (p_select_disable_slave) else $error("fault with select off");

endmodule

// file: sfi_spi_peer.sv
// Far-side serial device: a mode 1 slave answering the block's master,
// and a master driving select, clock and data when the block is a slave.
// Assumes the bench resolves each line from the enables of both parties.
`timescale 1ns/100ps
module sfi_spi_peer (
  // Line levels as resolved by the bench
  input  wire logic sck,
  input  wire logic mosi,
  input  wire logic miso,
  // Levels offered while the block does not drive
  output logic      miso_drv,
  output logic      sck_drv,
  output logic      mosi_drv,
  output logic      ss_n
);
  logic [7:0] tx;  // Reply byte in the slave role
  logic [7:0] rx;  // Byte taken in the slave role
  int         n;   // Bits shifted in the slave role

  // Idle: clock low, select released
  initial begin
    tx = 8'h00;
    rx = 8'h00;
    n = 8;
    miso_drv = 1'b0;
    sck_drv = 1'b0;
    mosi_drv = 1'b0;
    ss_n = 1'b1;
  end

  // Shift out on the leading edge; after the byte the line toggles, never holds
  always @(posedge sck) begin
    miso_drv <= (n < 8) ? tx[7-n] : ~miso_drv;
    n <= n + 1;
  end

  // Sample on the trailing edge
  always @(negedge sck) rx <= {rx[6:0], mosi};

  // Arm the reply for the next byte
  task automatic load(input logic [7:0] b);
    tx = b;
    n = 0;
  endtask

  // Master role, mode 1, slow enough for the block's pin synchronisers
  task automatic xfer(input logic [7:0] m, input int nbits, output logic [7:0] r);
    r = 8'h00;
    ss_n = 1'b0;
    #400;
    for (int i = 0; i < nbits; i++) begin
      sck_drv = 1'b1;
      mosi_drv = m[7-i];
      #400;
      sck_drv = 1'b0;
      r = {r[6:0], miso};
      #400;
    end
    ss_n = 1'b1;
    mosi_drv = ~mosi_drv;
    #400;
  endtask
endmodule

// file: tb_spi_fault_irq_control.sv
// Self-checking bench for the serial fault, interrupt and control block.
// Assumes sfi_core answers APB with no wait and the peer model on its pins.
`timescale 1ns/100ps
module tb_spi_fault_irq_control;
  import sfi_pkg::*;
  logic              clk, arst_n, psel, penable, pwrite, pready, pslverr, irq;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd_v;
  logic              sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  logic              p_sck, p_mosi, p_miso, ss_n, err_v, sck_prev;
  logic [7:0]        b, m, r;
  int                error_cnt, check_count, gap, last_gap, rt;
  // Each line is driven by whichever party enables it
  wire logic         sck_w  = sck_oe  ? sck_out  : p_sck;
  wire logic         mosi_w = mosi_oe ? mosi_out : p_mosi;
  wire logic         miso_w = miso_oe ? miso_out : p_miso;

  sfi_core i_dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sck_in(sck_w), .sck_out(sck_out), .sck_oe(sck_oe),
    .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w),
    .miso_out(miso_out), .miso_oe(miso_oe), .ss_n_in(ss_n), .irq(irq));
  sfi_spi_peer i_peer (.sck(sck_w), .mosi(mosi_w), .miso(miso_w), .miso_drv(p_miso),
    .sck_drv(p_sck), .mosi_drv(p_mosi), .ss_n(ss_n));

  always #20 clk = ~clk;

  // Clk cycles between line clock toggles, kept for the last pair
  always @(posedge clk) begin
    sck_prev <= sck_w;
    if (sck_w !== sck_prev) begin
      last_gap <= gap;
      gap <= 1;
    end else begin
      gap <= gap + 1;
    end
  end

  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, e, s);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // One APB transfer; an idle edge first so no signal is driven twice at once,
  // and it returns at the falling edge so registered results are read settled
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clk);
    if (n >= 20) begin
      error_cnt++;
      print_verdict();
    end
  endtask

  // Bounded wait for the request line
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) begin
      error_cnt++;
      print_verdict();
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    error_cnt = 0;
    check_count = 0;
    gap = 0;
    last_gap = 0;
    sck_prev = 1'b0;
    void'($urandom(32'h0849_3222));
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    apb(1'b0, CTRL_ADDR, 32'h0);
    chk("control reset", 32'h0000_0014, rd_v);
    apb(1'b1, 10'h004, 32'hffff_ffff);
    chk("unmapped error", 32'h1, err_v);
    b = 8'($urandom()) & 8'hbf;
    apb(1'b1, CTRL_ADDR, {24'h0, b});
    apb(1'b0, CTRL_ADDR, 32'h0);
    chk("control readback", {24'h0, b}, rd_v);
    $display("test registers done");
    // Master transfers at every rate code, invalid codes must stay idle
    for (rt = 0; rt < 8; rt++) begin
      apb(1'b1, CTRL_ADDR, 32'h34);
      m = 8'($urandom());
      b = 8'($urandom());
      i_peer.load(m);
      apb(1'b1, CTRL_ADDR, {24'h0, 8'h74 | {rt[2], 5'h00, rt[1:0]}});
      apb(1'b1, DATA_ADDR, {24'h0, b});
      if (rt == 0 || rt == 7) begin
        repeat (300) @(posedge clk);
        chk("idle irq", 32'h0, irq);
      end else begin
        wait_irq();
        chk("half period", 32'(2 << (rt - 1)), last_gap);
        chk("peer byte", b, i_peer.rx);
        apb(1'b0, STAT_ADDR, 32'h0);
        chk("master done", 32'h1, rd_v[ST_TC]);
        apb(1'b0, DATA_ADDR, 32'h0);
        // Reply bits need a half period longer than the pin synchroniser
        if (rt > 2) chk("master rx", m, rd_v);
        chk("irq cleared", 32'h0, irq);
      end
    end
    $display("test rates done");
    // Second byte lands before the first is read; rate /16 so the reply is seen
    apb(1'b1, CTRL_ADDR, 32'h34);
    apb(1'b1, CTRL_ADDR, 32'h77);
    m = 8'($urandom());
    i_peer.load(m);
    apb(1'b1, DATA_ADDR, 32'h5a);
    wait_irq();
    i_peer.load(~m);
    apb(1'b1, DATA_ADDR, 32'ha5);
    rt = 0;
    while (i_peer.n < 8 && rt < 500) begin
      @(posedge clk);
      rt++;
    end
    if (rt >= 500) begin
      error_cnt++;
      print_verdict();
    end
    repeat (20) @(posedge clk);
    apb(1'b0, STAT_ADDR, 32'h0);
    chk("overrun", 32'h1, rd_v[ST_OVR]);
    apb(1'b0, DATA_ADDR, 32'h0);
    chk("kept byte", m, rd_v);
    apb(1'b0, STAT_ADDR, 32'h0);
    chk("overrun cleared", 32'h0, rd_v[ST_OVR]);
    apb(1'b1, STAT_ADDR, 32'h2);
    chk("empty irq", 32'h1, irq);
    apb(1'b1, STAT_ADDR, 32'h1);
    chk("empty irq off", 32'h0, irq);
    $display("test overrun done");
    // Select pulled low under a master
    apb(1'b1, CTRL_ADDR, 32'h55);
    i_peer.xfer(8'h00, 0, r);
    chk("fault irq", 32'h1, irq);
    apb(1'b0, CTRL_ADDR, 32'h0);
    chk("master fault control", 32'h05, rd_v);
    apb(1'b0, STAT_ADDR, 32'h0);
    chk("master fault", 32'h1, rd_v[ST_MODE_FAULT_FLAG]);
    $display("test master fault done");
    // Slave bytes, an aborted byte and a fresh one
    apb(1'b1, CTRL_ADDR, 32'h44);
    b = 8'($urandom());
    m = 8'($urandom());
    apb(1'b1, DATA_ADDR, {24'h0, b});
    i_peer.xfer(m, 8, r);
    chk("slave tx", b, r);
    apb(1'b0, STAT_ADDR, 32'h0);
    chk("slave done", 32'h1, rd_v[ST_TC]);
    apb(1'b0, DATA_ADDR, 32'h0);
    chk("slave rx", m, rd_v);
    i_peer.xfer(8'hff, 3, r);
    chk("output floats", 32'h0, miso_oe);
    apb(1'b0, STAT_ADDR, 32'h0);
    chk("fault mid byte", 32'h1, rd_v[ST_MODE_FAULT_FLAG]);
    m = 8'($urandom());
    i_peer.xfer(m, 8, r);
    apb(1'b0, STAT_ADDR, 32'h0);
    apb(1'b0, DATA_ADDR, 32'h0);
    chk("fresh byte", m, rd_v);
    $display("test slave done");
    // Select disable against the phase bit
    apb(1'b1, CTRL_ADDR, 32'h64);
    i_peer.xfer(8'h00, 0, r);
    apb(1'b0, STAT_ADDR, 32'h0);
    chk("no fault", 32'h0, rd_v[ST_MODE_FAULT_FLAG]);
    apb(1'b1, CTRL_ADDR, 32'h60);
    // Leaving the always-selected setting faults at once; clear that first
    apb(1'b0, STAT_ADDR, 32'h0);
    i_peer.xfer(8'h00, 0, r);
    chk("fault irq held", 32'h0, irq);
    apb(1'b0, STAT_ADDR, 32'h0);
    chk("phase zero fault", 32'h1, rd_v[ST_MODE_FAULT_FLAG]);
    $display("test select disable done");
    print_verdict();
  end
endmodule
